// ==== core/ptb_tag_regs.vh ====
`ifndef PTB_TAG_REGS_VH
`define PTB_TAG_REGS_VH

// Memory geometry: sixteen blocks of sixteen bits
`define PTB_ADDR_W 4
`define PTB_DATA_W 16
`define PTB_BLOCKS 16
// Block that holds the tag identifier
`define PTB_ID_BLOCK 4'h0
// Acknowledge preamble pattern and its length
`define PTB_PREAMBLE 8'haa
`define PTB_PRE_BITS 5'h08
`define PTB_BLK_BITS 5'h10
// Command codes from the downlink decoder
`define PTB_CMD_INIT 3'h0
`define PTB_CMD_READ 3'h1
`define PTB_CMD_WRITE 3'h2
`define PTB_CMD_END 3'h3
`define PTB_CMD_SLEEP 3'h4
// Data encoding selections
`define PTB_ENC_NRZ 2'h0
`define PTB_ENC_BIP 2'h1
`define PTB_ENC_MAN 2'h2
// Modulation selections
`define PTB_MOD_ASK 2'h0
`define PTB_MOD_FSK 2'h1
`define PTB_MOD_PSK 2'h2
// Carrier cycles per subcarrier half period for FSK zero and one
`define PTB_FSK0_HALF 3'h4
`define PTB_FSK1_HALF 3'h5

`endif

// ==== core/ptb_mem.v ====
`timescale 1ns/100ps
`default_nettype none
`include "ptb_tag_regs.vh"

// Block memory with registered read data
module ptb_mem (
  input wire sys_clk,
  input wire clk_en,
  input wire wr_en,
  input wire [`PTB_ADDR_W-1:0] addr,
  input wire [`PTB_DATA_W-1:0] wdata,
  output reg [`PTB_DATA_W-1:0] rdata_r
);

  // Storage array, contents survive reset like a non-volatile array
  reg [`PTB_DATA_W-1:0] mem_r [0:`PTB_BLOCKS-1];

  // Write port and registered read port
  always @(posedge sys_clk) begin
    if (clk_en) begin
      if (wr_en) begin
        mem_r[addr] <= wdata;
      end
      rdata_r <= mem_r[addr];
    end
  end

endmodule // ptb_mem

`default_nettype wire

// ==== core/ptb_tag.v ====
// Summary of operation
// (R1) Powered tag shifts memory bits out per period
// (R2) Switch shorts antenna following encoded bit
// (R3) Supports ASK NRZ/Manchester, FSK and PSK
// (R4) Interrogator opens session with initiating command
// (R5) Read/write tag answers initiate with identifier
// (R6) Interrogator then selects read, write or sleep
// (R7) Read command sends block, then waits
// (R8) Write stores block, then echoes it back
// (R9) Interrogator ends session with end command
// (R10) End answered by 8-bit preamble, then sleep
// (R11) Sleep holds switch open, sends nothing
// (R12) NRZ passes bits straight to output
// (R13) Biphase toggles every boundary, mid for zero
// (R14) Reader flags boundaries without transition
// (R15) Manchester boundary transitions only when needed
// (R16) FSK zero Fc/8, one Fc/10
// (R17) PSK inverts subcarrier phase 180 degrees
// (R18) Manchester one mid transition, direction per bit
// (R19) Bit period counts configurable carrier cycles
// (R20) Read-only tag repeats memory cyclically
`timescale 1ns/100ps
`default_nettype none
`include "ptb_tag_regs.vh"

module ptb_tag (
  input wire sys_clk,
  input wire rstn,
  input wire clk_en,
  input wire carrier_in,
  input wire power_ok,
  input wire rw_tag,
  input wire [1:0] enc_sel,
  input wire [1:0] mod_sel,
  input wire [6:0] half_cycles,
  input wire cmd_valid,
  input wire [2:0] cmd_code,
  input wire [`PTB_ADDR_W-1:0] cmd_addr,
  input wire [`PTB_DATA_W-1:0] cmd_data,
  output reg mod_sw_r,
  output reg cmd_ready_r,
  output reg tx_busy_r,
  output reg asleep_r
);

  // Sequencer states
  localparam [2:0] S_OFF = 3'h0;
  localparam [2:0] S_IDLE = 3'h1;
  localparam [2:0] S_WRITE = 3'h2;
  localparam [2:0] S_FETCH = 3'h3;
  localparam [2:0] S_LOAD = 3'h4;
  localparam [2:0] S_ARM = 3'h5;
  localparam [2:0] S_SEND = 3'h6;
  localparam [2:0] S_SLEEP = 3'h7;

  // Next encoded level at a half-bit edge
  function enc_step;
    input [1:0] mode;
    input lvl;
    input bitv;
    input mid;
    begin
      case (mode)
        `PTB_ENC_BIP: enc_step = mid ? (bitv ? lvl : ~lvl) : ~lvl;
        `PTB_ENC_MAN: enc_step = mid ? bitv : ~bitv;
        default: enc_step = bitv;
      endcase
    end
  endfunction

  // Carrier synchroniser and filtered level
  reg car1_r, car2_r, car3_r, car_f_r;
  // Power-good synchroniser and filtered level
  reg pwr1_r, pwr2_r, pwr3_r, pwr_f_r;
  // Carrier rising edge seen in the system domain
  wire car_rise = (car2_r == car3_r) & car2_r & ~car_f_r;
  // Half-bit timer and bit phase
  reg [6:0] half_cnt_r;
  reg phase_r;
  wire half_tick = car_rise & (half_cnt_r >= half_cycles - 7'h01);
  wire boundary = half_tick & phase_r;
  // Sequencer
  reg [2:0] state_r, state_nxt;
  reg [`PTB_DATA_W-1:0] shreg_r;
  reg [4:0] bits_left_r;
  reg [`PTB_ADDR_W-1:0] addr_r;
  reg [`PTB_DATA_W-1:0] wdata_r;
  reg cur_bit_r;
  reg pre_pend_r;
  reg ident_r;
  reg processed_r;
  // Encoder level and subcarrier
  reg lvl_r;
  reg [2:0] sub_cnt_r;
  reg sub_r;
  reg mod_nxt;
  wire [`PTB_DATA_W-1:0] mem_rdata;
  wire mem_we = (state_r == S_WRITE);
  wire sending = (state_r == S_SEND);
  wire frame_done = boundary & sending & (bits_left_r == 5'h00);

  // Block memory
  ptb_mem u_mem (
    .sys_clk(sys_clk),
    .clk_en(clk_en),
    .addr(addr_r),
    .wr_en(mem_we),
    .wdata(wdata_r),
    .rdata_r(mem_rdata)
  );

  // Input synchronisers, change accepted when stages two and three agree
  always @(posedge sys_clk) begin
    if (!rstn) begin
      car1_r <= 1'b0;
      car2_r <= 1'b0;
      car3_r <= 1'b0;
      car_f_r <= 1'b0;
      pwr1_r <= 1'b0;
      pwr2_r <= 1'b0;
      pwr3_r <= 1'b0;
      pwr_f_r <= 1'b0;
    end else if (clk_en) begin
      car1_r <= carrier_in;
      car2_r <= car1_r;
      car3_r <= car2_r;
      pwr1_r <= power_ok;
      pwr2_r <= pwr1_r;
      pwr3_r <= pwr2_r;
      if (car2_r == car3_r) begin
        car_f_r <= car3_r;
      end
      if (pwr2_r == pwr3_r) begin
        pwr_f_r <= pwr3_r;
      end
    end
  end

  // (R19) carrier-counted bit timing
  always @(posedge sys_clk) begin
    if (!rstn) begin
      half_cnt_r <= 7'h00;
      phase_r <= 1'b0;
    end else if (clk_en) begin
      if (!pwr_f_r) begin
        half_cnt_r <= 7'h00;
        phase_r <= 1'b0;
      end else if (half_tick) begin
        half_cnt_r <= 7'h00;
        phase_r <= ~phase_r;
      end else if (car_rise) begin
        half_cnt_r <= half_cnt_r + 7'h01;
      end
    end
  end

  // Next sequencer state
  always @* begin
    state_nxt = state_r;
    case (state_r)
      S_OFF: begin
        if (pwr_f_r) begin
          state_nxt = rw_tag ? S_IDLE : S_FETCH;
        end
      end
      S_IDLE: begin
        if (cmd_valid) begin
          case (cmd_code)
            `PTB_CMD_INIT: state_nxt = S_FETCH;
            `PTB_CMD_READ: state_nxt = ident_r ? S_FETCH : S_IDLE;
            `PTB_CMD_WRITE: state_nxt = ident_r ? S_WRITE : S_IDLE;
            `PTB_CMD_END: state_nxt = processed_r ? S_LOAD : S_IDLE;
            `PTB_CMD_SLEEP: state_nxt = ident_r ? S_SLEEP : S_IDLE;
            default: state_nxt = S_IDLE;
          endcase
        end
      end
      S_WRITE: state_nxt = S_FETCH;
      S_FETCH: state_nxt = S_LOAD;
      S_LOAD: state_nxt = S_ARM;
      S_ARM: begin
        if (boundary) begin
          state_nxt = S_SEND;
        end
      end
      S_SEND: begin
        if (frame_done) begin
          if (!rw_tag) begin
            state_nxt = S_SEND;
          end else if (pre_pend_r) begin
            state_nxt = S_SLEEP;
          end else begin
            state_nxt = S_IDLE;
          end
        end
      end
      S_SLEEP: state_nxt = S_SLEEP;
      default: state_nxt = S_OFF;
    endcase
    // Loss of power drops everything
    if (!pwr_f_r) begin
      state_nxt = S_OFF;
    end
  end

  // Sequencer registers and shifter
  always @(posedge sys_clk) begin
    if (!rstn) begin
      state_r <= S_OFF;
      shreg_r <= {`PTB_DATA_W{1'b0}};
      bits_left_r <= 5'h00;
      addr_r <= `PTB_ID_BLOCK;
      wdata_r <= {`PTB_DATA_W{1'b0}};
      cur_bit_r <= 1'b0;
      pre_pend_r <= 1'b0;
      ident_r <= 1'b0;
      processed_r <= 1'b0;
    end else if (clk_en) begin
      state_r <= state_nxt;
      if (state_r == S_OFF) begin
        // Fresh session after each power-up
        addr_r <= `PTB_ID_BLOCK;
        ident_r <= 1'b0;
        processed_r <= 1'b0;
        pre_pend_r <= 1'b0;
      end
      if (state_r == S_IDLE && cmd_valid) begin
        case (cmd_code)
          // (R5) identifier answers the initiate
          `PTB_CMD_INIT: begin
            addr_r <= `PTB_ID_BLOCK;
            ident_r <= 1'b1;
          end
          // (R7) requested block
          `PTB_CMD_READ: begin
            addr_r <= cmd_addr;
            processed_r <= ident_r;
          end
          // (R8) store then echo
          `PTB_CMD_WRITE: begin
            addr_r <= cmd_addr;
            wdata_r <= cmd_data;
            processed_r <= ident_r;
          end
          // (R10) acknowledge with preamble
          `PTB_CMD_END: pre_pend_r <= processed_r;
          default: pre_pend_r <= pre_pend_r;
        endcase
      end
      if (state_r == S_LOAD) begin
        // Frame payload: preamble or the fetched block
        if (pre_pend_r) begin
          shreg_r <= {`PTB_PREAMBLE, 8'h00};
          bits_left_r <= `PTB_PRE_BITS;
        end else begin
          shreg_r <= mem_rdata;
          bits_left_r <= `PTB_BLK_BITS;
        end
        // (R20) prefetch following block for repetition
        if (!rw_tag) begin
          addr_r <= addr_r + 4'h1;
        end
      end
      // (R1) one stored bit per bit period
      if (boundary && (state_r == S_ARM || sending)) begin
        if (sending && bits_left_r == 5'h00 && !rw_tag) begin
          // (R20) wrap into next block with no gap
          cur_bit_r <= mem_rdata[`PTB_DATA_W-1];
          shreg_r <= {mem_rdata[`PTB_DATA_W-2:0], 1'b0};
          bits_left_r <= `PTB_BLK_BITS - 5'h01;
          addr_r <= addr_r + 4'h1;
        end else begin
          cur_bit_r <= shreg_r[`PTB_DATA_W-1];
          shreg_r <= {shreg_r[`PTB_DATA_W-2:0], 1'b0};
          bits_left_r <= bits_left_r - 5'h01;
        end
      end
    end
  end

  // Bit presented at the coming boundary
  wire next_bit = (bits_left_r == 5'h00) ? mem_rdata[`PTB_DATA_W-1]
                                        : shreg_r[`PTB_DATA_W-1];

  // Encoder level and subcarrier generation
  always @(posedge sys_clk) begin
    if (!rstn) begin
      lvl_r <= 1'b0;
      sub_cnt_r <= 3'h0;
      sub_r <= 1'b0;
    end else if (clk_en) begin
      // Read-only wrap keeps encoding into the next block, no gap
      if (half_tick && sending && !(frame_done && rw_tag)) begin
        // (R12) (R13) (R15) (R18) per-mode half-bit step
        lvl_r <= enc_step(enc_sel, lvl_r, phase_r ? next_bit : cur_bit_r,
                          ~phase_r);
      end else if (boundary && state_r == S_ARM) begin
        // (R13) first boundary of a frame
        lvl_r <= enc_step(enc_sel, lvl_r, shreg_r[`PTB_DATA_W-1], 1'b0);
      end
      if (car_rise) begin
        if (mod_sel == `PTB_MOD_FSK) begin
          // (R16) half period of four or five carrier cycles
          if (sub_cnt_r >= (lvl_r ? `PTB_FSK1_HALF : `PTB_FSK0_HALF)
              - 3'h1) begin
            sub_cnt_r <= 3'h0;
            sub_r <= ~sub_r;
          end else begin
            sub_cnt_r <= sub_cnt_r + 3'h1;
          end
        end else begin
          // (R17) Fc/2 reference subcarrier
          sub_cnt_r <= 3'h0;
          sub_r <= ~sub_r;
        end
      end
    end
  end

  // Switch drive selected by modulation scheme
  always @* begin
    case (mod_sel)
      `PTB_MOD_FSK: mod_nxt = sub_r;
      // (R17) phase inversion carries the bit
      `PTB_MOD_PSK: mod_nxt = sub_r ^ lvl_r;
      default: mod_nxt = lvl_r;
    endcase
  end

  // Registered outputs
  always @(posedge sys_clk) begin
    if (!rstn) begin
      mod_sw_r <= 1'b0;
      cmd_ready_r <= 1'b0;
      tx_busy_r <= 1'b0;
      asleep_r <= 1'b0;
    end else if (clk_en) begin
      // (R2) (R3) (R11) switch follows encoder only while sending
      mod_sw_r <= (state_nxt == S_SEND) & mod_nxt;
      cmd_ready_r <= (state_nxt == S_IDLE);
      tx_busy_r <= (state_nxt == S_SEND) | (state_nxt == S_ARM);
      asleep_r <= (state_nxt == S_SLEEP);
    end
  end

endmodule // ptb_tag

`default_nettype wire

// ==== verif/ptb_tag_props.sv ====
`timescale 1ns/100ps
`default_nettype none
`include "ptb_tag_regs.vh"
// Port-level watcher of the tag core
module ptb_tag_props (
  input wire logic sys_clk,
  input wire logic rstn,
  input wire logic clk_en,
  input wire logic carrier_in,
  input wire logic power_ok,
  input wire logic rw_tag,
  input wire logic [1:0] enc_sel,
  input wire logic [1:0] mod_sel,
  input wire logic [6:0] half_cycles,
  input wire logic cmd_valid,
  input wire logic [2:0] cmd_code,
  input wire logic [`PTB_ADDR_W-1:0] cmd_addr,
  input wire logic [`PTB_DATA_W-1:0] cmd_data,
  input wire logic mod_sw_r,
  input wire logic cmd_ready_r,
  input wire logic tx_busy_r,
  input wire logic asleep_r
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rstn);
  // Command taken at this edge
  wire logic acc = cmd_valid && cmd_ready_r && clk_en;
  a_init_taken: assert property (
    acc && cmd_code == `PTB_CMD_INIT |=> !cmd_ready_r) else $error("init lost");
  a_bad_code: assert property (
    acc && cmd_code > `PTB_CMD_SLEEP |=> cmd_ready_r) else $error("bad code taken");
  a_fall_cause: assert property (
    $fell(cmd_ready_r) |-> $past(cmd_valid)) else $error("ready fell alone");
  a_frame_soon: assert property (
    $fell(cmd_ready_r) && $past(cmd_code) != `PTB_CMD_SLEEP |-> ##[1:150] tx_busy_r)
    else $error("no frame");
  a_busy_excl: assert property (
    tx_busy_r |-> !cmd_ready_r) else $error("busy and ready");
  a_sleep_quiet: assert property (
    asleep_r |-> !mod_sw_r && !tx_busy_r && !cmd_ready_r) else $error("sleep busy");
  a_sleep_holds: assert property (
    asleep_r && power_ok |=> asleep_r) else $error("woke early");
  a_unpowered: assert property (
    !power_ok [*8] |-> ##2 (!tx_busy_r && !mod_sw_r)) else $error("sends unpowered");
  a_ro_stream: assert property (
    !rw_tag |-> !cmd_ready_r && !asleep_r) else $error("read-only waits");
  cover property ($rose(asleep_r));
  cover property ($rose(tx_busy_r) && rw_tag);
  cover property (acc && cmd_code == `PTB_CMD_WRITE);
endmodule // ptb_tag_props
bind ptb_tag ptb_tag_props ptb_tag_props_i (.sys_clk, .rstn, .clk_en,
  .carrier_in, .power_ok, .rw_tag, .enc_sel, .mod_sel, .half_cycles,
  .cmd_valid, .cmd_code, .cmd_addr, .cmd_data, .mod_sw_r, .cmd_ready_r,
  .tx_busy_r, .asleep_r);
`default_nettype wire

// ==== verif/ptb_reader.sv ====
`timescale 1ns/100ps
`default_nettype none
// Reader field: carrier only while on
module ptb_reader (
  input wire logic field_on,
  output logic carrier,
  output logic power
);
  // Carrier stands low with field off
  initial begin
    carrier = 1'b0;
    #3.3;
    forever #62.5 carrier = field_on ? ~carrier : 1'b0;
  end
  // Energy after first carrier edge
  initial power = 1'b0;
  always @(posedge carrier or negedge field_on) power <= field_on;
endmodule // ptb_reader
`default_nettype wire

// ==== verif/tb.sv ====
`timescale 1ns/100ps
`default_nettype none
`include "ptb_tag_regs.vh"
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin n_errors++; \
  $display("Error %0t got %h exp %h", $time, g, e); end end
module tb;
  logic sys_clk, rstn, field_on, carrier_in, power_ok, rw_tag, cmd_valid;
  logic [1:0] enc_sel, mod_sel;
  logic [2:0] cmd_code;
  logic [3:0] cmd_addr;
  logic [15:0] cmd_data, d;
  logic mod_sw_r, cmd_ready_r, tx_busy_r, asleep_r;
  logic lv = 1'b0, h1, h2, bv, e, pv;
  int rise_n = 0; // Carrier rises since the field came on
  logic [15:0] mem_m [16]; // Model of block contents
  logic exp_q [$]; // Expected bits, oldest first
  int n_errors = 0, n_tests = 0, tg;
  ptb_reader ptb_reader_i (.field_on, .carrier(carrier_in), .power(power_ok));
  ptb_tag ptb_tag_i (.sys_clk, .rstn, .clk_en(1'b1), .carrier_in,
    .power_ok, .rw_tag, .enc_sel, .mod_sel, .half_cycles(7'h04),
    .cmd_valid, .cmd_code, .cmd_addr, .cmd_data, .mod_sw_r, .cmd_ready_r,
    .tx_busy_r, .asleep_r);
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end
  task report_and_stop;
    $display("Checks %0d errors %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // Bounded wait for ready (0) or sleep (1)
  task wait_sig(input int k);
    int i;
    i = 0;
    while ((k ? asleep_r : cmd_ready_r) !== 1'b1) begin
      @(posedge sys_clk);
      i++;
      if (i > 4000) begin
        n_errors++;
        report_and_stop;
      end
    end
  endtask
  // One-cycle command strobe
  task cmd(input [2:0] c, input [3:0] a, input [15:0] v);
    @(posedge sys_clk);
    #1 {cmd_valid, cmd_code, cmd_addr, cmd_data} = {1'b1, c, a, v};
    @(posedge sys_clk);
    #1 cmd_valid = 1'b0;
  endtask
  // Queue bits MSB first
  task push(input [15:0] v, input int n);
    for (int i = n - 1; i >= 0; i--) exp_q.push_back(v[i]);
  endtask
  // Command expected to be ignored
  task refused(input [2:0] c);
    cmd(c, 4'h0, 16'h0);
    repeat (3) @(posedge sys_clk);
    `CHK(cmd_ready_r, 1'b1)
  endtask
  // Count carrier rises; boundaries fall on every eighth from the ninth
  always @(posedge carrier_in or negedge field_on)
    rise_n <= field_on ? rise_n + 1 : 0;
  // Decode ASK frames at quarter points; level carries across frames
  initial begin
    forever begin
      // Tag seen armed three edges after a boundary rise sends next edge
      @(posedge carrier_in iff rise_n % 8 == 0 && rise_n > 0);
      repeat (3) @(posedge sys_clk);
      #1;
      if (tx_busy_r === 1'b1) repeat (25) @(posedge sys_clk);
      while (tx_busy_r === 1'b1) begin
        h1 = mod_sw_r;
        repeat (50) @(posedge sys_clk);
        h2 = mod_sw_r;
        if (mod_sel == `PTB_MOD_ASK) begin
          bv = (enc_sel == `PTB_ENC_BIP) ? h1 === h2 : h2;
          `CHK(h1, enc_sel == `PTB_ENC_BIP ? ~lv : enc_sel == `PTB_ENC_MAN ? ~h2 : h2)
          if (exp_q.size() > 0) begin
            e = exp_q.pop_front();
            if (!$isunknown(e)) `CHK(bv, e)
          end
        end
        lv = h2;
        repeat (27) @(posedge sys_clk);
        if (tx_busy_r === 1'b1) repeat (23) @(posedge sys_clk);
      end
    end
  end
  initial begin
    {rstn, field_on, rw_tag, cmd_valid, cmd_code, enc_sel, mod_sel} = 11'h100;
    {cmd_addr, cmd_data} = 20'h0;
    void'($urandom(66));
    repeat (6) @(posedge sys_clk);
    #1 rstn = 1'b1;
    // One session per encoding
    for (int k = 0; k < 3; k++) begin
      enc_sel = k[1:0];
      field_on = 1'b1;
      wait_sig(0);
      refused(`PTB_CMD_READ);
      push(mem_m[0], 16);
      cmd(`PTB_CMD_INIT, 4'h0, 16'h0);
      wait_sig(0);
      refused(`PTB_CMD_END);
      d = $urandom;
      mem_m[k] = d;
      push(d, 16);
      cmd(`PTB_CMD_WRITE, k[3:0], d);
      wait_sig(0);
      push(d, 16);
      cmd(`PTB_CMD_READ, k[3:0], 16'h0);
      wait_sig(0);
      refused(3'h7);
      // Last session leaves by sleep, others by end
      if (k == 2) cmd(`PTB_CMD_SLEEP, 4'h0, 16'h0);
      else begin
        push({8'h00, `PTB_PREAMBLE}, 8);
        cmd(`PTB_CMD_END, 4'h0, 16'h0);
      end
      wait_sig(1);
      repeat (300) @(posedge sys_clk);
      #1 field_on = 1'b0;
      repeat (30) @(posedge sys_clk);
    end
    // Read-only stream of the first blocks
    #1 {rstn, rw_tag, enc_sel} = 4'h2;
    repeat (6) @(posedge sys_clk);
    #1 rstn = 1'b1;
    for (int b = 0; b < 3; b++) push(mem_m[b], 16);
    field_on = 1'b1;
    repeat (5200) @(posedge sys_clk);
    `CHK(exp_q.size(), 0)
    // Subcarrier toggle counts for FSK and PSK
    for (int m = 1; m < 3; m++) begin
      #1 field_on = 1'b0;
      mod_sel = m[1:0];
      repeat (30) @(posedge sys_clk);
      #1 field_on = 1'b1;
      repeat (400) @(posedge sys_clk);
      tg = 0;
      pv = mod_sw_r;
      repeat (200) begin
        @(posedge sys_clk);
        if (mod_sw_r !== pv) tg++;
        pv = mod_sw_r;
      end
      `CHK(m == 1 ? (tg > 1 && tg < 6) : tg > 11, 1'b1)
    end
    report_and_stop;
  end
endmodule // tb
`default_nettype wire
